// ==== design/bss_top.sv ====
// backup supply sequencer: power-up, core reset, shutdown, backup mode
`timescale 1ns/1ns
`default_nettype none

module bss_top #(
	parameter int DATA_W = 32
) (
	input  wire logic                       core_clk,
	input  wire logic                       rst,
	input  wire logic                       backup_reset_pin_n,
	input  wire logic                       force_wakeup_pin,
	input  wire logic                       regulator_good,
	input  wire logic                       brownout_detect,
	input  wire logic                       frame_end_strobe,
	input  wire logic                       charge_pump_active,
	input  wire logic                       wake_request,
	input  wire logic [3:0]                 addr,
	input  wire logic [DATA_W-1:0]          wr_data,
	input  wire logic                       wr_en,
	input  wire logic                       rd_en,
	output logic      [DATA_W-1:0]          rd_data,
	output logic                            backup_hold,
	output logic                            regulator_enable,
	output logic                            regulator_deep,
	output logic      [bss_pkg::VSEL_W-1:0] regulator_vsel,
	output logic                            core_reset_n,
	output logic                            processor_stop,
	output logic                            display_reset_n,
	output logic                            charge_pump_off,
	output logic                            flash_power,
	output logic                            flash_reset_n,
	output logic                            sram_power,
	output logic                            timekeeping_reset_n,
	output logic                            clock_power
);
	import bss_pkg::*;

	// ==========================================================
	// reset: asynchronous assert, synchronous release
	logic       arst_w;
	logic [1:0] rsync_r;
	logic       sys_rst_w;

	// pin or power-on reset acts at once
	assign arst_w    = rst | ~backup_reset_pin_n;
	assign sys_rst_w = ~rsync_r[1];

	// release shifted in on the slow clock
	always_ff @(posedge core_clk or posedge arst_w) begin
		if (arst_w) begin
			rsync_r <= 2'h0;
		end else begin
			rsync_r <= {rsync_r[0], 1'b1};
		end
	end

	// ==========================================================
	// pin synchronisers
	logic [5:0] pin_raw_w;
	logic [5:0] sync1_r;
	logic [5:0] sync2_r;
	logic       fw_low_w;
	logic       good_s;
	logic       bod_s;
	logic       eof_s;
	logic       pump_s;
	logic       wake_s;

	assign pin_raw_w = {wake_request, charge_pump_active, frame_end_strobe,
		brownout_detect, regulator_good, force_wakeup_pin};

	// two stages per pin
	always_ff @(posedge core_clk or posedge sys_rst_w) begin
		if (sys_rst_w) begin
			sync1_r <= 6'h01;
			sync2_r <= 6'h01;
		end else begin
			sync1_r <= pin_raw_w;
			sync2_r <= sync1_r;
		end
	end

	assign fw_low_w = ~sync2_r[0]; // pin is active low
	assign good_s   = sync2_r[1];
	assign bod_s    = sync2_r[2];
	assign eof_s    = sync2_r[3];
	assign pump_s   = sync2_r[4];
	assign wake_s   = sync2_r[5];

	// ==========================================================
	// register bus decode
	logic wr_ctrl_w;
	logic wr_mode_w;
	logic rd_stat_w;

	assign wr_ctrl_w = wr_en && (addr == OFF_CONTROL);
	assign wr_mode_w = wr_en && (addr == OFF_MODE);
	assign rd_stat_w = rd_en && (addr == OFF_STATUS);

	// mode register
	logic              bod_en_r;
	logic              loss_en_r;
	logic              reg_mode_r;
	logic              reg_deep_r;
	logic              retain_r;
	logic [VSEL_W-1:0] vsel_r;

	always_ff @(posedge core_clk or posedge sys_rst_w) begin
		if (sys_rst_w) begin
			bod_en_r   <= RST_BOD_EN;
			loss_en_r  <= RST_LOSS_EN;
			reg_mode_r <= RST_MODE;
			reg_deep_r <= RST_DEEP;
			retain_r   <= RST_RETAIN;
			vsel_r     <= RST_VSEL;
		end else if (wr_mode_w) begin
			bod_en_r   <= wr_data[BIT_BOD_RST_EN];
			loss_en_r  <= wr_data[BIT_LOSS_RST_EN];
			reg_mode_r <= wr_data[BIT_REG_MODE];
			reg_deep_r <= wr_data[BIT_REG_DEEP];
			retain_r   <= wr_data[BIT_SRAM_RETAIN];
			vsel_r     <= wr_data[POS_VSEL +: VSEL_W];
		end
	end

	// command stage, one pulse per write
	logic       cmd_sd_r;
	logic       cmd_eof_r;
	logic       cmd_roff_r;

	always_ff @(posedge core_clk or posedge sys_rst_w) begin
		if (sys_rst_w) begin
			cmd_sd_r   <= 1'b0;
			cmd_eof_r  <= 1'b0;
			cmd_roff_r <= 1'b0;
		end else begin
			cmd_sd_r   <= wr_ctrl_w && wr_data[BIT_SHUTDOWN];
			cmd_eof_r  <= wr_ctrl_w && wr_data[BIT_SHUTDOWN_EOF];
			cmd_roff_r <= wr_ctrl_w && wr_data[BIT_REG_OFF];
		end
	end

	// ==========================================================
	// sequencer
	bss_state_t state_r;
	bss_state_t state_nxt;
	logic [4:0] deb_cnt_r;
	logic       good_prev_r;
	logic       sd_eof_r;
	logic       deb_done_w;

	assign deb_done_w = (deb_cnt_r == DEBOUNCE_CYCLES - 5'h01);

	// state decision
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_DEBOUNCE: begin
				if (deb_done_w) begin
					state_nxt = fw_low_w ? ST_POWERUP : ST_OFF;
				end
			end
			ST_OFF:      state_nxt = ST_OFF;
			// good seen in two samples in a row
			ST_POWERUP: begin
				if (good_s && good_prev_r) begin
					state_nxt = ST_RUN;
				end
			end
			ST_RUN: begin
				if (cmd_sd_r || cmd_eof_r) begin
					state_nxt = ST_SD_CORE;
				end else if (cmd_roff_r) begin
					state_nxt = ST_ROFF_RST;
				end
			end
			ST_SD_CORE:  state_nxt = ST_SD_REG;
			ST_SD_REG: begin
				if (!pump_s) begin
					state_nxt = ST_SD_FLASH;
				end else begin
					state_nxt = sd_eof_r ? ST_SD_EOF : ST_SD_DISP;
				end
			end
			ST_SD_EOF: begin
				if (eof_s) begin
					state_nxt = ST_SD_DISP;
				end
			end
			ST_SD_DISP:  state_nxt = ST_SD_PUMP;
			ST_SD_PUMP:  state_nxt = ST_SD_FLASH;
			ST_SD_FLASH: state_nxt = ST_SD_SRAM;
			ST_SD_SRAM:  state_nxt = ST_SD_TKRST;
			ST_SD_TKRST: state_nxt = ST_SD_CLK;
			ST_SD_CLK:   state_nxt = ST_OFF;
			// one stop cycle before supply off
			ST_ROFF_RST: state_nxt = ST_ROFF_STP;
			ST_ROFF_STP: state_nxt = ST_BACKUP;
			ST_BACKUP: begin
				if (wake_s) begin
					state_nxt = ST_POWERUP;
				end
			end
		endcase
	end

	// every reset restarts at the debounce
	always_ff @(posedge core_clk or posedge sys_rst_w) begin
		if (sys_rst_w) begin
			state_r     <= ST_DEBOUNCE;
			deb_cnt_r   <= 5'h00;
			good_prev_r <= 1'b0;
			sd_eof_r    <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			deb_cnt_r   <= deb_done_w ? deb_cnt_r : deb_cnt_r + 5'h01;
			good_prev_r <= good_s;
			sd_eof_r    <= (state_r == ST_RUN) ? cmd_eof_r : sd_eof_r;
		end
	end

	// ==========================================================
	// brownout and regulation loss core reset
	logic       loss_arm_w;
	logic       bod_trig_w;
	logic       loss_trig_w;
	logic [1:0] low_cnt_r;
	logic [1:0] hold_r;
	logic [1:0] hold_nxt;
	logic       loss_act_r;
	logic       loss_act_nxt;

	// armed in normal mode with regulator on, never deep
	assign loss_arm_w  = (state_r == ST_RUN) && loss_en_r && !reg_mode_r
		&& !reg_deep_r;
	assign loss_trig_w = loss_arm_w && !good_s
		&& (low_cnt_r == LOSS_LOW_CYCLES - 2'h1);
	assign bod_trig_w  = (state_r == ST_RUN) && bod_en_r && bod_s;
	// two cycles at least, after a loss trigger longer while good low
	assign hold_nxt     = (bod_trig_w || loss_trig_w) ? CORE_HOLD_CYCLES :
		(hold_r != 2'h0) ? hold_r - 2'h1 : 2'h0;
	assign loss_act_nxt = loss_trig_w | (loss_act_r & ~good_s);

	always_ff @(posedge core_clk or posedge sys_rst_w) begin
		if (sys_rst_w) begin
			low_cnt_r  <= 2'h0;
			hold_r     <= 2'h0;
			loss_act_r <= 1'b0;
		end else begin
			low_cnt_r  <= (loss_arm_w && !good_s && low_cnt_r != 2'h3) ?
				low_cnt_r + 2'h1 : (good_s ? 2'h0 : low_cnt_r);
			hold_r     <= hold_nxt;
			loss_act_r <= loss_act_nxt;
		end
	end

	// ==========================================================
	// status flags, set wins over read clear
	logic first_powerup_flag_set_w;
	logic first_flag_r;
	logic loss_flag_r;

	// first power-up only on the debounce path
	assign first_powerup_flag_set_w = (state_r == ST_DEBOUNCE) && (state_nxt == ST_POWERUP);

	always_ff @(posedge core_clk or posedge sys_rst_w) begin
		if (sys_rst_w) begin
			first_flag_r <= 1'b0;
			loss_flag_r  <= 1'b0;
		end else begin
			first_flag_r <= first_powerup_flag_set_w | (first_flag_r & ~rd_stat_w);
			loss_flag_r  <= loss_trig_w | (loss_flag_r & ~rd_stat_w);
		end
	end

	// ==========================================================
	// read data, valid only in the cycle after the strobe
	logic [DATA_W-1:0] status_w;
	logic [DATA_W-1:0] mode_w;
	logic [DATA_W-1:0] rd_mux_w;

	always_comb begin
		status_w = '0;
		status_w[BIT_FIRST_PWRUP] = first_flag_r;
		status_w[BIT_LOSS_FLAG]   = loss_flag_r;
		status_w[BIT_BACKUP_MODE] = (state_r == ST_BACKUP);
		status_w[POS_STATE +: 4]  = state_r;
		mode_w = '0;
		mode_w[BIT_BOD_RST_EN]    = bod_en_r;
		mode_w[BIT_LOSS_RST_EN]   = loss_en_r;
		mode_w[BIT_REG_MODE]      = reg_mode_r;
		mode_w[BIT_REG_DEEP]      = reg_deep_r;
		mode_w[BIT_SRAM_RETAIN]   = retain_r;
		mode_w[POS_VSEL +: VSEL_W] = vsel_r;
	end

	// control reads as zero, like unmapped space
	assign rd_mux_w = !rd_en ? '0 :
		(addr == OFF_STATUS) ? status_w :
		(addr == OFF_MODE) ? mode_w : '0;

	// ==========================================================
	// output decode from the next state
	logic reg_on_w;
	logic flash_on_w;
	logic sram_on_w;
	logic core_run_w;

	// regulator, flash and SRAM rise with backup hold and fall before it
	assign reg_on_w   = state_nxt inside {ST_POWERUP, ST_RUN, ST_SD_CORE,
		ST_ROFF_RST, ST_ROFF_STP};
	assign flash_on_w = reg_on_w || (state_nxt inside {ST_SD_REG,
		ST_SD_EOF, ST_SD_DISP, ST_SD_PUMP});
	// SRAM on with core; backup follows retain bit
	assign sram_on_w  = flash_on_w || (state_nxt == ST_SD_FLASH)
		|| (state_nxt == ST_BACKUP && retain_r);
	// core reset low outside run and while holding
	assign core_run_w = (state_nxt == ST_RUN) && (hold_nxt == 2'h0)
		&& !loss_act_nxt;

	always_ff @(posedge core_clk or posedge sys_rst_w) begin
		if (sys_rst_w) begin
			rd_data             <= '0;
			backup_hold         <= 1'b0;
			regulator_enable    <= 1'b0;
			regulator_deep      <= 1'b0;
			regulator_vsel      <= RST_VSEL;
			core_reset_n        <= 1'b0;
			processor_stop      <= 1'b0;
			display_reset_n     <= 1'b0;
			charge_pump_off     <= 1'b0;
			flash_power         <= 1'b0;
			flash_reset_n       <= 1'b0;
			sram_power          <= 1'b0;
			timekeeping_reset_n <= 1'b0;
			clock_power         <= 1'b0;
		end else begin
			rd_data             <= rd_mux_w;
			backup_hold         <= !(state_nxt inside {ST_OFF, ST_DEBOUNCE});
			regulator_enable    <= reg_on_w;
			// deep mode only while regulator on
			regulator_deep      <= reg_on_w && reg_deep_r;
			regulator_vsel      <= vsel_r;
			core_reset_n        <= core_run_w;
			processor_stop      <= state_nxt inside {ST_ROFF_STP, ST_BACKUP};
			display_reset_n     <= !(state_nxt inside {ST_SD_DISP,
				ST_SD_PUMP, ST_SD_FLASH, ST_SD_SRAM, ST_SD_TKRST,
				ST_SD_CLK, ST_OFF, ST_DEBOUNCE});
			charge_pump_off     <= state_nxt inside {ST_SD_PUMP,
				ST_SD_FLASH, ST_SD_SRAM, ST_SD_TKRST, ST_SD_CLK, ST_OFF};
			flash_power         <= flash_on_w;
			flash_reset_n       <= flash_on_w;
			sram_power          <= sram_on_w;
			timekeeping_reset_n <= !(state_nxt inside {ST_SD_TKRST,
				ST_SD_CLK, ST_OFF, ST_DEBOUNCE});
			clock_power         <= !(state_nxt inside {ST_SD_CLK, ST_OFF,
				ST_DEBOUNCE});
		end
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst_w);

	sequence s_core_then_reg;
		!core_reset_n && regulator_enable ##1 !regulator_enable;
	endsequence

	sequence s_flash_sram_clk;
		!flash_power && sram_power ##1 !sram_power && timekeeping_reset_n
		##1 !timekeeping_reset_n && clock_power ##1 !clock_power
		##1 !backup_hold;
	endsequence

	a_off_no_hold: assert property (
		(state_r == ST_DEBOUNCE && deb_done_w && !fw_low_w)
		|=> !backup_hold [*3])
		else $error("backup hold raised without wakeup pin");

	a_core_release: assert property (
		$rose(core_reset_n) && $past(state_r) == ST_POWERUP
		|-> $past(good_s) && $past(good_s, 2))
		else $error("core reset released before good was confirmed");

	a_first_flag: assert property (
		rd_stat_w && !first_powerup_flag_set_w |=> !first_flag_r)
		else $error("first power-up flag survived a status read");

	a_bod_hold: assert property (
		bod_trig_w |=> !core_reset_n [*2])
		else $error("brownout reset shorter than two cycles");

	a_loss_hold: assert property (
		loss_trig_w |=> (!core_reset_n [*2]) ##1 (!core_reset_n || good_s))
		else $error("regulation loss reset released too early");

	a_loss_deep: assert property (
		reg_deep_r && !loss_act_r |=> !loss_flag_r || $past(loss_flag_r))
		else $error("regulation loss fired in deep mode");

	a_loss_flag: assert property (
		loss_trig_w |=> loss_flag_r)
		else $error("regulation loss flag not set");

	a_shutdown_order: assert property (
		$rose(state_r == ST_SD_CORE) |-> s_core_then_reg)
		else $error("core and regulator shutdown out of order");

	a_shutdown_tail: assert property (
		$rose(state_r == ST_SD_FLASH) |-> s_flash_sram_clk)
		else $error("flash, sram, clock shutdown out of order");

	a_eof_wait: assert property (
		state_r == ST_SD_EOF && !eof_s |=> display_reset_n)
		else $error("display reset before frame end");

	a_roff_latency: assert property (
		wr_ctrl_w && wr_data[BIT_REG_OFF] && state_r == ST_RUN
		&& !wr_data[BIT_SHUTDOWN] && !wr_data[BIT_SHUTDOWN_EOF]
		|-> ##[1:2] !core_reset_n)
		else $error("regulator off did not reset core in time");

	a_roff_stop: assert property (
		$fell(regulator_enable) && state_r == ST_BACKUP
		|-> $past(processor_stop) && !$past(processor_stop, 2))
		else $error("processor not stopped one cycle before supply off");

	a_sram_core: assert property (
		regulator_enable |-> sram_power)
		else $error("sram off while core supply on");

	a_wake_sram: assert property (
		state_r == ST_BACKUP && wake_s |=> sram_power)
		else $error("sram not restored on backup exit");

endmodule

`default_nettype wire

// ==== design/bss_pkg.sv ====
// constants, register map and state codes of the backup supply sequencer
package bss_pkg;

	// ==========================================================
	// register map
	localparam logic [3:0] OFF_CONTROL = 4'h0;
	localparam logic [3:0] OFF_MODE    = 4'h4;
	localparam logic [3:0] OFF_STATUS  = 4'h8;

	// control register command bits, single shot
	localparam int BIT_SHUTDOWN     = 0;
	localparam int BIT_SHUTDOWN_EOF = 1;
	localparam int BIT_REG_OFF      = 2;

	// mode register fields
	localparam int BIT_BOD_RST_EN   = 0;
	localparam int BIT_LOSS_RST_EN  = 1;
	localparam int BIT_REG_MODE     = 2;
	localparam int BIT_REG_DEEP     = 3;
	localparam int BIT_SRAM_RETAIN  = 4;
	localparam int POS_VSEL         = 8;
	localparam int VSEL_W           = 4;

	// status register fields
	localparam int BIT_FIRST_PWRUP  = 0;
	localparam int BIT_LOSS_FLAG    = 1;
	localparam int BIT_BACKUP_MODE  = 2;
	localparam int POS_STATE        = 4;

	// mode register reset values
	localparam logic              RST_BOD_EN  = 1'b0;
	localparam logic              RST_LOSS_EN = 1'b0;
	localparam logic              RST_MODE    = 1'b0;
	localparam logic              RST_DEEP    = 1'b0;
	localparam logic              RST_RETAIN  = 1'b0;
	localparam logic [VSEL_W-1:0] RST_VSEL    = 4'h0;

	// ==========================================================
	// timing counts in slow clock cycles
	localparam logic [4:0] DEBOUNCE_CYCLES = 5'h1e;
	localparam logic [1:0] CORE_HOLD_CYCLES = 2'h2;
	localparam logic [1:0] LOSS_LOW_CYCLES  = 2'h2;

	// ==========================================================
	// sequencer states
	typedef enum logic [3:0] {
		ST_DEBOUNCE = 4'h0,
		ST_OFF      = 4'h1,
		ST_POWERUP  = 4'h2,
		ST_RUN      = 4'h3,
		ST_SD_CORE  = 4'h4,
		ST_SD_REG   = 4'h5,
		ST_SD_EOF   = 4'h6,
		ST_SD_DISP  = 4'h7,
		ST_SD_PUMP  = 4'h8,
		ST_SD_FLASH = 4'h9,
		ST_SD_SRAM  = 4'ha,
		ST_SD_TKRST = 4'hb,
		ST_SD_CLK   = 4'hc,
		ST_ROFF_RST = 4'hd,
		ST_ROFF_STP = 4'he,
		ST_BACKUP   = 4'hf
	} bss_state_t;

endpackage

// ==== tb/bss_partner.sv ====
// regulator model that answers the sequencer's enable with a good flag
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// regulator: output valid a few cycles after enable, lost on command
module bss_partner #(
	parameter int RAMP = 3
) (
	input  wire logic core_clk,
	input  wire logic regulator_enable,
	input  wire logic lose_good,
	output var  logic regulator_good
);
	int ramp_r = 0;

	// ramp counter restarts whenever the switch opens
	always_ff @(posedge core_clk) begin
		if (!regulator_enable)
			ramp_r <= 0;
		else if (ramp_r < RAMP)
			ramp_r <= ramp_r + 1;
	end

	// good only once settled and while no loss is commanded
	assign regulator_good = regulator_enable && ramp_r == RAMP && !lose_good;
endmodule
`default_nettype wire

// ==== tb/bss_top_tb.sv ====
// self-checking bench of the backup supply sequencer
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
`define WAITC(c) for (w = 0; w < 400 && !(c); w++) @(posedge core_clk);

// ==========================================================
// bench top
module bss_top_tb;
	import bss_pkg::*;
	logic core_clk = 0, rst = 1, backup_reset_pin_n = 1, force_wakeup_pin = 0;
	logic regulator_good, brownout_detect = 0, frame_end_strobe = 0;
	logic charge_pump_active = 1, wake_request = 0, wr_en = 0, rd_en = 0;
	logic lose_good = 0, p1 = 0;
	logic [3:0] addr = 4'h0, regulator_vsel;
	logic [31:0] wr_data = 32'h0, rd_data, rnd = 32'h26177b03;
	logic backup_hold, regulator_enable, regulator_deep, core_reset_n;
	logic processor_stop, display_reset_n, charge_pump_off, flash_power;
	logic flash_reset_n, sram_power, timekeeping_reset_n, clock_power;
	logic [8:0] v;
	logic [63:0] e;
	logic [63:0] q[$];
	int failures = 0, compares = 0, cyc = 0, w, n, r, i, j;
	int t[9];

	bss_top u_bss_top (.core_clk, .rst, .backup_reset_pin_n,
		.force_wakeup_pin, .regulator_good, .brownout_detect,
		.frame_end_strobe, .charge_pump_active, .wake_request, .addr,
		.wr_data, .wr_en, .rd_en, .rd_data, .backup_hold, .regulator_enable,
		.regulator_deep, .regulator_vsel, .core_reset_n, .processor_stop,
		.display_reset_n, .charge_pump_off, .flash_power, .flash_reset_n,
		.sram_power, .timekeeping_reset_n, .clock_power);
	bss_partner u_bss_partner (.core_clk, .regulator_enable, .lose_good,
		.regulator_good);

	// ==========================================================
	// clock, timeout and verdict
	always #5 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			report_and_stop();
		end
	end

	task automatic report_and_stop;
		if (failures == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	// ==========================================================
	// bus master tasks; reads leave a masked note in the queue
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge core_clk);
		wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] m, ex);
		@(posedge core_clk);
		addr <= a;
		rd_en <= 1'b1;
		q.push_back({m, ex & m});
		@(posedge core_clk);
		rd_en <= 1'b0;
	endtask

	// read data monitor: takes the oldest note when data stands
	always @(posedge core_clk) begin
		if (p1) begin
			e = q.pop_front();
			`CHK(rd_data & e[63:32], e[31:0])
		end
		p1 <= rd_en;
	end

	// length of the next core reset pulse in cycles
	task automatic low_len(output int k);
		k = 0;
		for (int c = 0; c < 8 && core_reset_n; c++) @(posedge core_clk);
		while (core_reset_n === 1'b0 && k < 100) begin
			@(posedge core_clk);
			k++;
		end
	endtask

	// ==========================================================
	// main sequence
	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		// power-up with the wakeup pin held low
		`WAITC(core_reset_n === 1'b1)
		`CHK(w < 400, 1'b1)
		`CHK({backup_hold, flash_power, flash_reset_n, sram_power}, 4'hf)
		`CHK({clock_power, timekeeping_reset_n}, 2'h3)
		rd(OFF_STATUS, 32'h3, 32'h1);
		rd(OFF_STATUS, 32'h1, 32'h0);
		rd(OFF_MODE, 32'hffffffff, 32'h0);
		rd(OFF_CONTROL, 32'hffffffff, 32'h0);
		rd(4'hc, 32'hffffffff, 32'h0);
		// random voltage, deep and retain settings
		repeat (4) begin
			rnd = xs(rnd);
			wr(OFF_MODE, rnd & 32'hf1c);
			rd(OFF_MODE, 32'hfff, rnd & 32'hf1c);
			`CHK(regulator_vsel, rnd[11:8])
			`CHK(regulator_deep, rnd[3])
			`CHK(sram_power, 1'b1)
		end
		// brownout pulse with reset enable
		wr(OFF_MODE, 32'h1);
		@(posedge core_clk) brownout_detect <= 1'b1;
		@(posedge core_clk) brownout_detect <= 1'b0;
		low_len(n);
		`CHK(n >= 2, 1'b1)
		// regulation loss ignored in deep mode, then with mode select set
		for (r = 0; r < 2; r++) begin
			wr(OFF_MODE, r ? 32'h6 : 32'ha);
			@(posedge core_clk) lose_good <= 1'b1;
			repeat (8) begin
				@(posedge core_clk);
				`CHK(core_reset_n, 1'b1)
			end
			lose_good <= 1'b0;
			repeat (4) @(posedge core_clk);
		end
		// regulation loss in normal mode
		wr(OFF_MODE, 32'h2);
		@(posedge core_clk) lose_good <= 1'b1;
		repeat (10) @(posedge core_clk);
		`CHK(core_reset_n, 1'b0)
		lose_good <= 1'b0;
		low_len(n);
		`CHK(n >= 1 && n < 9, 1'b1)
		rd(OFF_STATUS, 32'h2, 32'h2);
		rd(OFF_STATUS, 32'h2, 32'h0);
		// regulator off into backup mode, with and without retention
		for (r = 0; r < 2; r++) begin
			wr(OFF_MODE, r ? 32'h10 : 32'h0);
			`CHK(sram_power, 1'b1)
			wr(OFF_CONTROL, 32'h4);
			for (w = 0; w < 5 && core_reset_n; w++) @(posedge core_clk);
			`CHK(w <= 3, 1'b1)
			`WAITC(processor_stop === 1'b1)
			`CHK(processor_stop, 1'b1)
			`CHK(regulator_enable, 1'b1)
			@(posedge core_clk);
			`CHK(regulator_enable, 1'b0)
			`CHK(sram_power, r[0])
			`CHK(core_reset_n, 1'b0)
			rd(OFF_STATUS, 32'h4, 32'h4);
			@(posedge core_clk) wake_request <= 1'b1;
			`WAITC(core_reset_n === 1'b1)
			wake_request <= 1'b0;
			`CHK({sram_power, regulator_enable}, 2'h3)
		end
		// backup reset pin in mid-run, then restart
		@(posedge core_clk) backup_reset_pin_n <= 1'b0;
		#1;
		`CHK({backup_hold, regulator_enable, sram_power, core_reset_n}, 4'h0)
		@(posedge core_clk) backup_reset_pin_n <= 1'b1;
		for (w = 0; w < 60 && !backup_hold; w++) @(posedge core_clk);
		`CHK(w >= 30 && w < 42, 1'b1)
		`WAITC(core_reset_n === 1'b1)
		// shutdown after frame end, then plain shutdown, pump active
		for (r = 0; r < 2; r++) begin
			for (j = 0; j < 9; j++) t[j] = 99;
			wr(OFF_CONTROL, r ? 32'h1 : 32'h2);
			for (i = 0; i < 60; i++) begin
				@(posedge core_clk);
				frame_end_strobe <= (i >= 10 && i < 14);
				v = {core_reset_n, regulator_enable, display_reset_n,
					!charge_pump_off, flash_power, sram_power,
					timekeeping_reset_n, clock_power, backup_hold};
				for (j = 0; j < 9; j++)
					if (v[j] === 1'b0 && t[j] == 99) t[j] = i;
			end
			for (j = 0; j < 8; j++) `CHK(t[j + 1] < t[j], 1'b1)
			`CHK(t[0] < 60, 1'b1)
			`CHK(t[6] > 10, r == 0)
			`CHK(flash_reset_n, 1'b0)
			// restart the supply for the next command
			@(posedge core_clk) backup_reset_pin_n <= 1'b0;
			@(posedge core_clk) backup_reset_pin_n <= 1'b1;
			`WAITC(core_reset_n === 1'b1)
		end
		// pin released before debounce ends: supply stays off
		@(posedge core_clk) begin
			force_wakeup_pin <= 1'b1;
			backup_reset_pin_n <= 1'b0;
		end
		@(posedge core_clk) backup_reset_pin_n <= 1'b1;
		repeat (60) @(posedge core_clk);
		`CHK(backup_hold, 1'b0)
		repeat (4) @(posedge core_clk);
		report_and_stop();
	end
endmodule
`default_nettype wire
